// file: core/pcrp_channel.sv
// current-value logic of one pulse counter channel: linear/ring, presets, z phase
// Notes on behaviour
// - linear type keeps count inside the signed 32-bit range.
// - linear down count below minimum sets underflow bit 1, value stays at minimum.
// - linear up count above maximum sets overflow bit 2, value stays at maximum.
// - every preset clears both limit flags; counting resumes from preset value.
// - linear overflow or underflow raises channel error code 3100.
// - ring up count from upper limit minus one loads lower limit.
// - ring down count from lower limit loads upper limit minus one.
// - ring type never raises overflow or underflow error.
// - new ring limits apply only at rising edge of count enable.
// - z phase trigger is rising, falling, both edges, or level.
// - selected z trigger loads preset value regardless of count enable.
// - option sets sticky z seen flag on z preset; ignored for level trigger.
// - while z seen flag is set, no preset source changes the count.
// - z seen clear command clears flag and allows presets again.
// - preset value write replaces the stored preset value.
// - preset sources are z phase, program command, coincidence and two functions.
// - ring range depends on count position relative to limits at preset or enable.
// - rising edge of program preset command loads stored preset value.
`timescale 1ns/1ps
`default_nettype none
module pcrp_channel
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire pcrp_pkg::pcrp_pulse_type count_pulse,
   input wire pcrp_pkg::pcrp_ctype_type counter_type,
   input wire pcrp_pkg::pcrp_trig_type z_trigger_sel,
   input wire logic z_seen_enable,
   input wire logic zphase_in,
   input wire logic counting_allow_cmd,
   input wire logic program_preset_cmd,
   input wire logic zphase_seen_clear_cmd,
   input wire pcrp_pkg::pcrp_fn_preset_type fn_preset,
   input wire logic preset_value_write_op,
   input wire logic signed [31:0] preset_value_in,
   input wire logic ring_limits_write_op,
   input wire pcrp_pkg::pcrp_limits_type ring_limits_in,
   output logic [15:0] count_value_low_word,
   output logic [15:0] count_value_high_word,
   output logic [15:0] count_limit_flags,
   output logic zphase_preset_seen,
   output logic [15:0] channel_error_code,
   output logic channel_error
);
   // ****************************************
   // state
   // ****************************************
   logic signed [31:0] count_reg;
   logic signed [31:0] count_next;
   logic signed [31:0] preset_reg;
   pcrp_pkg::pcrp_limits_type pending_limits_reg;
   pcrp_pkg::pcrp_limits_type active_limits_reg;
   logic underflow_reg;
   logic underflow_next;
   logic overflow_reg;
   logic overflow_next;
   logic seen_reg;
   logic seen_next;
   logic error_reg;
   logic error_next;
   // ring span chosen at preset or enable: inside the limits, or the outer wrap
   logic ring_outer_reg;
   logic ring_outer_next;
   logic [15:0] flags_next;
   logic [15:0] code_next;

   // ****************************************
   // edge detection
   // ****************************************
   logic z_rise;
   logic z_fall;
   logic z_level;
   logic prog_rise;
   logic allow_rise;
   logic allow_level;

   pcrp_edge z_edge
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .level_in(zphase_in),
      .rise(z_rise),
      .fall(z_fall),
      .level_q(z_level)
   );

   pcrp_edge prog_edge
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .level_in(program_preset_cmd),
      .rise(prog_rise),
      .fall(),
      .level_q()
   );

   pcrp_edge allow_edge
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .level_in(counting_allow_cmd),
      .rise(allow_rise),
      .fall(),
      .level_q(allow_level)
   );

   // ****************************************
   // preset decode
   // ****************************************
   wire is_level_trig = (z_trigger_sel == pcrp_pkg::pcrp_trig_level);
   wire z_hit = (z_trigger_sel == pcrp_pkg::pcrp_trig_rise) ? z_rise :
                (z_trigger_sel == pcrp_pkg::pcrp_trig_fall) ? z_fall :
                (z_trigger_sel == pcrp_pkg::pcrp_trig_both) ? (z_rise | z_fall) :
                zphase_in;
   wire fn_any = fn_preset.coincidence | fn_preset.disable_preset | fn_preset.latch_replace;
   wire preset_req = z_hit | prog_rise | fn_any;
   wire preset_do = preset_req & ~seen_reg;
   wire z_sets_seen = z_hit & ~seen_reg & z_seen_enable & ~is_level_trig;

   // limits taken at enable rising edge; the new span decision uses them
   pcrp_pkg::pcrp_limits_type lim;
   assign lim = allow_rise ? pending_limits_reg : active_limits_reg;
   wire signed [31:0] upper_m1 = lim.upper - pcrp_pkg::count_one;
   wire signed [31:0] base_val = preset_do ? preset_reg : count_reg;
   // outer span when the value lies outside [lower, upper-1]
   wire outside_now = (base_val < lim.lower) || (base_val > upper_m1);
   wire take_span = preset_do | allow_rise;

   // ****************************************
   // counting
   // ****************************************
   wire step_ok = count_pulse.step & allow_level & counting_allow_cmd;
   wire is_ring = (counter_type == pcrp_pkg::pcrp_ring);
   wire at_max = (count_reg == pcrp_pkg::count_max);
   wire at_min = (count_reg == pcrp_pkg::count_min);
   wire signed [31:0] inc_val = count_reg + pcrp_pkg::count_one;
   wire signed [31:0] dec_val = count_reg - pcrp_pkg::count_one;
   // inner span wraps at the limits; outer span wraps the other way round them
   wire ring_up_wrap = ring_outer_reg ? (count_reg == lim.lower - pcrp_pkg::count_one)
                                      : (count_reg == upper_m1);
   wire ring_dn_wrap = ring_outer_reg ? (count_reg == lim.upper) : (count_reg == lim.lower);
   wire signed [31:0] ring_up_val = ring_outer_reg ? lim.upper : lim.lower;
   wire signed [31:0] ring_dn_val = ring_outer_reg ? (lim.lower - pcrp_pkg::count_one)
                                                   : upper_m1;

   always_comb
   begin
      count_next = count_reg;
      underflow_next = underflow_reg;
      overflow_next = overflow_reg;
      error_next = error_reg;
      // a preset in the same cycle as a step wins; the step is lost
      if (preset_do)
      begin
         count_next = preset_reg;
         underflow_next = 1'b0;
         overflow_next = 1'b0;
      end
      else if (step_ok && is_ring)
      begin
         if (!count_pulse.down)
            count_next = ring_up_wrap ? ring_up_val : inc_val;
         else
            count_next = ring_dn_wrap ? ring_dn_val : dec_val;
      end
      else if (step_ok)
      begin
         if (!count_pulse.down)
         begin
            if (at_max)
            begin
               overflow_next = 1'b1;
               error_next = 1'b1;
            end
            else
               count_next = inc_val;
         end
         else
         begin
            if (at_min)
            begin
               underflow_next = 1'b1;
               error_next = 1'b1;
            end
            else
               count_next = dec_val;
         end
      end
   end

   // span choice holds from one preset or enable edge to the next
   always_comb
   begin
      ring_outer_next = ring_outer_reg;
      if (take_span)
         ring_outer_next = outside_now;
   end

   always_comb
   begin
      seen_next = seen_reg;
      // clear first; a same-cycle z detection sets the flag only if it was clear before
      if (zphase_seen_clear_cmd)
         seen_next = 1'b0;
      if (z_sets_seen)
         seen_next = 1'b1;
   end

   // ****************************************
   // status words
   // ****************************************
   always_comb
   begin
      flags_next = '0;
      flags_next[pcrp_pkg::flag_underflow_bit] = underflow_next;
      flags_next[pcrp_pkg::flag_overflow_bit] = overflow_next;
   end
   // error stays sticky: only reset clears it, a preset does not
   assign code_next = error_next ? pcrp_pkg::error_code_overunder
                                 : pcrp_pkg::error_code_none;

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= pcrp_pkg::count_reset_value;
         underflow_reg <= 1'b0;
         overflow_reg <= 1'b0;
         seen_reg <= 1'b0;
         error_reg <= 1'b0;
         ring_outer_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         underflow_reg <= underflow_next;
         overflow_reg <= overflow_next;
         seen_reg <= seen_next;
         error_reg <= error_next;
         ring_outer_reg <= ring_outer_next;
      end
   end

   // ****************************************
   // stored preset value and ring limits
   // ****************************************
   // limits wait in a pending copy so a write cannot disturb a running ring
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         preset_reg <= pcrp_pkg::count_reset_value;
         pending_limits_reg <= '0;
         active_limits_reg <= '0;
      end
      else
      begin
         if (preset_value_write_op)
            preset_reg <= preset_value_in;
         if (ring_limits_write_op)
            pending_limits_reg <= ring_limits_in;
         if (allow_rise)
            active_limits_reg <= pending_limits_reg;
      end
   end

   // ****************************************
   // outputs, all registered
   // ****************************************
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_value_low_word <= 16'h0000;
         count_value_high_word <= 16'h0000;
         count_limit_flags <= 16'h0000;
         zphase_preset_seen <= 1'b0;
         channel_error_code <= pcrp_pkg::error_code_none;
         channel_error <= 1'b0;
      end
      else
      begin
         count_value_low_word <= count_next[pcrp_pkg::half_width-1:0];
         count_value_high_word <= count_next[pcrp_pkg::count_width-1:pcrp_pkg::half_width];
         count_limit_flags <= flags_next;
         zphase_preset_seen <= seen_next;
         channel_error <= error_next;
         channel_error_code <= code_next;
      end
   end
endmodule
`default_nettype wire

// file: core/pcrp_pkg.sv
// package: constants and types for the pulse counter current-value channel
package pcrp_pkg;
   localparam int unsigned count_width = 32;
   localparam logic signed [31:0] count_min = 32'sh80000000;
   localparam logic signed [31:0] count_max = 32'sh7FFFFFFF;
   localparam logic signed [31:0] count_one = 32'sh00000001;
   localparam logic signed [31:0] count_reset_value = 32'sh00000000;
   localparam logic [15:0] error_code_none = 16'h0000;
   localparam logic [15:0] error_code_overunder = 16'h0C1C; // decimal 3100
   localparam int unsigned flag_underflow_bit = 1;
   localparam int unsigned flag_overflow_bit = 2;
   localparam int unsigned half_width = 16;
   // time that a lowered count enable must stand before ring limits may change
   localparam int unsigned enable_off_ms = 2;
   localparam int unsigned clock_mhz = 200;
   localparam int unsigned enable_off_cycles = enable_off_ms * 1000 * clock_mhz * 1000 / 1000;

   typedef enum logic [1:0]
   {
      pcrp_trig_rise = 2'b00,
      pcrp_trig_fall = 2'b01,
      pcrp_trig_both = 2'b10,
      pcrp_trig_level = 2'b11
   } pcrp_trig_type;

   typedef enum logic
   {
      pcrp_linear = 1'b0,
      pcrp_ring = 1'b1
   } pcrp_ctype_type;

   // one count pulse with its direction
   typedef struct packed
   {
      logic step;
      logic down;
   } pcrp_pulse_type;

   // the three function preset requests, one-cycle pulses
   typedef struct packed
   {
      logic coincidence;
      logic disable_preset;
      logic latch_replace;
   } pcrp_fn_preset_type;

   typedef struct packed
   {
      logic signed [31:0] upper;
      logic signed [31:0] lower;
   } pcrp_limits_type;
endpackage

// file: core/pcrp_edge.sv
// rising and falling edge detector for a synchronous level
`timescale 1ns/1ps
`default_nettype none
module pcrp_edge
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic level_in,
   output logic rise,
   output logic fall,
   output logic level_q
);
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         level_q <= 1'b0;
      else
         level_q <= level_in;
   end
   assign rise = level_in & ~level_q;
   assign fall = ~level_in & level_q;
endmodule
`default_nettype wire

// file: dv/pcrp_channel_asserts.sv
// checker: port-level assertions for the pulse counter channel
`timescale 1ns/1ps
`default_nettype none
module pcrp_channel_asserts
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire pcrp_pkg::pcrp_pulse_type count_pulse,
   input wire pcrp_pkg::pcrp_ctype_type counter_type,
   input wire pcrp_pkg::pcrp_trig_type z_trigger_sel,
   input wire logic zphase_in,
   input wire logic counting_allow_cmd,
   input wire logic program_preset_cmd,
   input wire logic zphase_seen_clear_cmd,
   input wire pcrp_pkg::pcrp_fn_preset_type fn_preset,
   input wire logic [15:0] count_value_low_word,
   input wire logic [15:0] count_value_high_word,
   input wire logic [15:0] count_limit_flags,
   input wire logic zphase_preset_seen,
   input wire logic [15:0] channel_error_code,
   input wire logic channel_error
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire logic [31:0] cnt = {count_value_high_word, count_value_low_word};
   // presets win over steps, so pinning is only judged with every source quiet
   wire logic idle = fn_preset == '0 && !program_preset_cmd && !zphase_in;
   wire logic lin = counter_type == pcrp_pkg::pcrp_linear;
   sequence live_step(logic dn);
      count_pulse == {1'h1, dn} && counting_allow_cmd && $past(counting_allow_cmd)
         && idle && !$past(zphase_in);
   endsequence
   sequence prog_rise;
      program_preset_cmd && !$past(program_preset_cmd) && !zphase_preset_seen;
   endsequence
   // ****
   // assertions
   // ****
   ovf_pin_a:
      assert property (lin && cnt == 32'h7FFFFFFF ##0 live_step(1'h0)
         |=> cnt == 32'h7FFFFFFF && count_limit_flags[2]) else $error("overflow not pinned");
   udf_pin_a:
      assert property (lin && cnt == 32'h80000000 ##0 live_step(1'h1)
         |=> cnt == 32'h80000000 && count_limit_flags[1]) else $error("underflow not pinned");
   flag_err_a:
      assert property ($rose(count_limit_flags[2]) || $rose(count_limit_flags[1])
         |-> channel_error && channel_error_code == 16'h0C1C) else $error("error code missing");
   ring_quiet_a:
      assert property (!lin |=> !$rose(|count_limit_flags[2:1])) else $error("ring raised flag");
   preset_clr_a:
      assert property (prog_rise |=> count_limit_flags[2:1] == 2'h0) else $error("flags kept");
   seen_block_a:
      assert property (zphase_preset_seen && !count_pulse.step |=> $stable(cnt))
         else $error("preset not blocked");
   seen_clear_a:
      assert property (zphase_seen_clear_cmd && !zphase_in && !$past(zphase_in)
         |=> !zphase_preset_seen) else $error("seen flag not cleared");
   level_noseen_a:
      assert property (z_trigger_sel == pcrp_pkg::pcrp_trig_level && !zphase_preset_seen
         |=> !zphase_preset_seen) else $error("level trigger set seen flag");
endmodule
bind pcrp_channel pcrp_channel_asserts u_pcrp_channel_asserts
(
   .core_clk(core_clk), .rst_n(rst_n), .count_pulse(count_pulse),
   .counter_type(counter_type), .z_trigger_sel(z_trigger_sel), .zphase_in(zphase_in),
   .counting_allow_cmd(counting_allow_cmd), .program_preset_cmd(program_preset_cmd),
   .zphase_seen_clear_cmd(zphase_seen_clear_cmd), .fn_preset(fn_preset),
   .count_value_low_word(count_value_low_word), .count_value_high_word(count_value_high_word),
   .count_limit_flags(count_limit_flags), .zphase_preset_seen(zphase_preset_seen),
   .channel_error_code(channel_error_code), .channel_error(channel_error)
);
`default_nettype wire

// file: dv/pcrp_pulse_src.sv
// partner model: pulse source driving count pulses and the z phase line
`timescale 1ns/1ps
`default_nettype none
module pcrp_pulse_src
(
   input wire logic core_clk,
   output pcrp_pkg::pcrp_pulse_type count_pulse,
   output logic zphase_in
);
   initial
   begin
      count_pulse = '0;
      zphase_in = 1'h0;
   end
   // random gaps of one to three idle cycles between pulses give fast and slow pulse trains
   task automatic steps(input int n, input logic dn);
      repeat (n)
      begin
         @(posedge core_clk);
         count_pulse <= {1'h1, dn};
         @(posedge core_clk);
         count_pulse <= '0;
         repeat ($urandom % 3) @(posedge core_clk);
      end
   endtask
   task automatic zpulse(input int w);
      @(posedge core_clk);
      zphase_in <= 1'h1;
      repeat (w) @(posedge core_clk);
      zphase_in <= 1'h0;
   endtask
endmodule
`default_nettype wire

// file: dv/pcrp_channel_tb.sv
// testbench: self-checking run of the pulse counter channel
`timescale 1ns/1ps
`default_nettype none
module pcrp_channel_tb;
   logic core_clk = 1'h0;
   logic rst_n = 1'h0;
   pcrp_pkg::pcrp_pulse_type count_pulse;
   logic zphase_in;
   pcrp_pkg::pcrp_ctype_type counter_type = pcrp_pkg::pcrp_linear;
   pcrp_pkg::pcrp_trig_type z_trigger_sel = pcrp_pkg::pcrp_trig_rise;
   logic z_seen_enable = 1'h0;
   logic counting_allow_cmd = 1'h0;
   logic program_preset_cmd = 1'h0;
   logic zphase_seen_clear_cmd = 1'h0;
   pcrp_pkg::pcrp_fn_preset_type fn_preset = '0;
   logic preset_value_write_op = 1'h0;
   logic signed [31:0] preset_value_in = 32'h0;
   logic ring_limits_write_op = 1'h0;
   pcrp_pkg::pcrp_limits_type ring_limits_in = '0;
   logic [15:0] count_value_low_word, count_value_high_word, count_limit_flags, err_code;
   logic zphase_preset_seen, channel_error, exp_err = 1'h0;
   logic [65:0] exp_q[$];
   logic [31:0] rv, rv2;
   int err_total = 0;
   int checks = 0;
   pcrp_pulse_src u_pcrp_pulse_src
   (
      .core_clk(core_clk), .count_pulse(count_pulse), .zphase_in(zphase_in)
   );
   pcrp_channel u_pcrp_channel
   (
      .core_clk(core_clk), .rst_n(rst_n), .count_pulse(count_pulse),
      .counter_type(counter_type), .z_trigger_sel(z_trigger_sel),
      .z_seen_enable(z_seen_enable), .zphase_in(zphase_in),
      .counting_allow_cmd(counting_allow_cmd), .program_preset_cmd(program_preset_cmd),
      .zphase_seen_clear_cmd(zphase_seen_clear_cmd), .fn_preset(fn_preset),
      .preset_value_write_op(preset_value_write_op), .preset_value_in(preset_value_in),
      .ring_limits_write_op(ring_limits_write_op), .ring_limits_in(ring_limits_in),
      .count_value_low_word(count_value_low_word), .count_value_high_word(count_value_high_word),
      .count_limit_flags(count_limit_flags), .zphase_preset_seen(zphase_preset_seen),
      .channel_error_code(err_code), .channel_error(channel_error)
   );
   initial
   begin
      forever #2.5 core_clk = ~core_clk;
   end
   // ****
   // tasks
   // ****
   task automatic check(input logic [65:0] seen_v, input logic [65:0] exp_v);
      checks++;
      if (seen_v !== exp_v)
      begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen_v, exp_v);
      end
   endtask
   task automatic close_out();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic note(input logic [31:0] c, input logic ovf, input logic udf, input logic s);
      repeat (2) @(posedge core_clk);
      exp_q.push_back({c, 13'h0, ovf, udf, 1'h0, s, exp_err, exp_err ? 16'h0C1C : 16'h0});
   endtask
   task automatic wr_preset(input logic [31:0] v);
      @(posedge core_clk);
      preset_value_in <= v;
      preset_value_write_op <= 1'h1;
      @(posedge core_clk);
      preset_value_write_op <= 1'h0;
   endtask
   task automatic load(input logic [31:0] v);
      wr_preset(v);
      program_preset_cmd <= 1'h1;
      @(posedge core_clk);
      program_preset_cmd <= 1'h0;
   endtask
   always @(negedge core_clk)
   begin
      if (exp_q.size() > 0)
         check({count_value_high_word, count_value_low_word, count_limit_flags,
            zphase_preset_seen, channel_error, err_code}, exp_q.pop_front());
   end
   initial
   begin
      #200us;
      err_total++;
      close_out();
   end
   // ****
   // main sequence
   // ****
   initial
   begin
      rv = $urandom(32'h0B2632CA);
      repeat (8) @(posedge core_clk);
      rst_n <= 1'h1;
      note(32'h0, 1'h0, 1'h0, 1'h0);
      load(32'h7FFFFFFD);
      note(32'h7FFFFFFD, 1'h0, 1'h0, 1'h0);
      counting_allow_cmd <= 1'h1;
      u_pcrp_pulse_src.steps(4, 1'h0);
      exp_err = 1'h1;
      note(32'h7FFFFFFF, 1'h1, 1'h0, 1'h0);
      load(32'h80000001);
      note(32'h80000001, 1'h0, 1'h0, 1'h0);
      u_pcrp_pulse_src.steps(3, 1'h1);
      note(32'h80000000, 1'h0, 1'h1, 1'h0);
      counting_allow_cmd <= 1'h0;
      counter_type <= pcrp_pkg::pcrp_ring;
      ring_limits_in <= {32'h5, 32'hFFFFFFFB};
      ring_limits_write_op <= 1'h1;
      @(posedge core_clk);
      ring_limits_write_op <= 1'h0;
      load(32'h3);
      counting_allow_cmd <= 1'h1;
      u_pcrp_pulse_src.steps(2, 1'h0);
      note(32'hFFFFFFFB, 1'h0, 1'h0, 1'h0);
      u_pcrp_pulse_src.steps(1, 1'h1);
      note(32'h4, 1'h0, 1'h0, 1'h0);
      counting_allow_cmd <= 1'h0;
      z_seen_enable <= 1'h1;
      for (int m = 0; m < 4; m++)
      begin
         z_trigger_sel <= pcrp_pkg::pcrp_trig_type'(m[1:0]);
         rv = $urandom;
         rv2 = $urandom;
         // stored value is live the next cycle, so the trigger needs no long gap
         wr_preset(rv);
         u_pcrp_pulse_src.zpulse(3);
         note(rv, 1'h0, 1'h0, m != 3);
         load(rv2);
         note(m != 3 ? rv : rv2, 1'h0, 1'h0, m != 3);
         zphase_seen_clear_cmd <= 1'h1;
         @(posedge core_clk);
         zphase_seen_clear_cmd <= 1'h0;
         load(rv2);
         note(rv2, 1'h0, 1'h0, 1'h0);
      end
      for (int b = 0; b < 3; b++)
      begin
         rv = $urandom;
         wr_preset(rv);
         fn_preset <= 3'h1 << b;
         @(posedge core_clk);
         fn_preset <= '0;
         note(rv, 1'h0, 1'h0, 1'h0);
      end
      // option off: an edge preset still loads, but leaves the seen flag low
      z_seen_enable <= 1'h0;
      z_trigger_sel <= pcrp_pkg::pcrp_trig_rise;
      rv = $urandom;
      wr_preset(rv);
      u_pcrp_pulse_src.zpulse(1);
      note(rv, 1'h0, 1'h0, 1'h0);
      for (int i = 0; i < 20 && exp_q.size() > 0; i++)
         @(posedge core_clk);
      if (exp_q.size() > 0)
         err_total++;
      close_out();
   end
endmodule
`default_nettype wire
